// *** rtl/crb_defines.vh ***
// constants for the cascade receiver byte capture block
`ifndef CRB_DEFINES_VH
`define CRB_DEFINES_VH

// ----------------------------------------
// data layout
// ----------------------------------------
`define CRB_DATA_W 9
`define CRB_WIDE_BIT 8

// ----------------------------------------
// timing
// ----------------------------------------
`define CRB_CLK_PERIOD_NS 10
`define CRB_FALL_DELAY_NS 20
`define CRB_FALL_DELAY_CYC ((`CRB_FALL_DELAY_NS + `CRB_CLK_PERIOD_NS - 1) / `CRB_CLK_PERIOD_NS)

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CRB_ADDR_W 4
`define CRB_REG_CTRL 4'h0
`define CRB_REG_STATUS 4'h4
`define CRB_REG_OUTDATA 4'h8
`define CRB_REG_WORDS 4'hC

// ----------------------------------------
// control fields
// ----------------------------------------
`define CRB_CTRL_SOFT_SYNC 0
`define CRB_CTRL_GATE 1
`define CRB_CTRL_RESET 32'h00000002
`define CRB_CTRL_GATE_RESET 1'b1

// ----------------------------------------
// status fields
// ----------------------------------------
`define CRB_ST_TAKEN 0
`define CRB_ST_HOLD 1
`define CRB_ST_ARMED 2
`define CRB_ST_FALL 3
`define CRB_ST_DEC_PEND 4

`endif

// *** rtl/crb_fall_delay.v ***
// fixed delay from catch-enable fall to byte-taken fall
`timescale 1ns/1ps
`default_nettype none

module crb_fall_delay #(
  parameter CYC = 2,
  parameter CW = 4
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // control
  input wire start,
  input wire abort,
  // status
  output reg busy,
  output wire done
);

  reg [CW-1:0] count;

  assign done = busy & (count == {CW{1'b0}});

  always @(posedge core_clk) begin
    if (!nrst) begin
      busy <= 1'b0;
      count <= {CW{1'b0}};
    end else if (abort) begin
      busy <= 1'b0;
      count <= {CW{1'b0}};
    end else if (start && !busy) begin
      busy <= 1'b1;
      count <= CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
    end else if (done) begin
      busy <= 1'b0;
    end else if (busy) begin
      count <= count - {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// *** rtl/crb_out_stage.v ***
// decoder latch and output latch with strobes
`timescale 1ns/1ps
`default_nettype none

module crb_out_stage #(
  parameter DW = 9
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // from input latch
  input wire release_byte,
  input wire [DW-1:0] in_data,
  input wire in_cmd,
  input wire in_viol,
  // outputs
  output reg [DW-1:0] data_out,
  output reg code_violation_out,
  output reg data_out_strobe,
  output reg command_out_strobe,
  output reg dec_pend
);

  reg [DW-1:0] dec_data;
  reg dec_cmd;
  reg dec_viol;

  // input latch to decoder latch on release
  always @(posedge core_clk) begin
    if (!nrst) begin
      dec_data <= {DW{1'b0}};
      dec_cmd <= 1'b0;
      dec_viol <= 1'b0;
      dec_pend <= 1'b0;
    end else begin
      dec_pend <= release_byte;
      if (release_byte) begin
        dec_data <= in_data;
        dec_cmd <= in_cmd;
        dec_viol <= in_viol;
      end
    end
  end

  // decoder latch to output latch one clock later, strobe with it
  always @(posedge core_clk) begin
    if (!nrst) begin
      data_out <= {DW{1'b0}};
      code_violation_out <= 1'b0;
      data_out_strobe <= 1'b0;
      command_out_strobe <= 1'b0;
    end else begin
      data_out_strobe <= dec_pend & ~dec_cmd;
      command_out_strobe <= dec_pend & dec_cmd;
      if (dec_pend) begin
        data_out <= dec_data;
        code_violation_out <= dec_viol;
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/crb_capture.v ***
// capture control of one receiver in a cascade sharing one serial line
`timescale 1ns/1ps
`default_nettype none
`include "crb_defines.vh"

module crb_capture #(
  parameter DW = `CRB_DATA_W,
  parameter FALL_CYC = `CRB_FALL_DELAY_CYC,
  parameter WORD_CW = 16
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // symbol classifier
  input wire sym_half,
  input wire sym_half_sync,
  input wire sym_done,
  input wire sym_sync,
  input wire sym_cmd,
  input wire sym_violation,
  input wire [DW-1:0] sym_data,
  // configuration pins
  input wire data_width_select,
  // cascade chain
  input wire catch_enable_in,
  output wire byte_taken_out,
  // parallel outputs
  output wire [DW-1:0] data_out,
  output wire code_violation_out,
  output wire data_out_strobe,
  output wire command_out_strobe,
  // register port
  input wire [`CRB_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata
);

  // ----------------------------------------
  // state encoding
  // ----------------------------------------
  // one-hot; state[1] doubles as the armed status bit
  localparam [4:0] S_WAIT = 5'h01;
  localparam [4:0] S_ARMED = 5'h02;
  localparam [4:0] S_HALF = 5'h04;
  localparam [4:0] S_FULL = 5'h08;
  localparam [4:0] S_FALL = 5'h10;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg [4:0] state;
  reg [4:0] next_state;
  reg taken;
  reg next_taken;
  reg ctrl_gate;
  reg soft_sync;
  reg [DW-1:0] in_data;
  reg in_cmd;
  reg in_viol;
  reg in_valid;
  reg [WORD_CW-1:0] words;
  reg load_in;
  reg release_byte;
  reg fall_start;
  reg fall_abort;
  reg [31:0] next_rdata;
  wire enable_ok;
  wire sync_evt;
  wire half_data;
  wire [DW-1:0] masked_data;
  wire fall_busy;
  wire fall_done;
  wire dec_pend;
  wire [4:0] status_bits;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [DW-1:0] width_mask;
    input [DW-1:0] d;
    input wide;
    begin
      width_mask = d;
      if (!wide) begin
        width_mask[`CRB_WIDE_BIT] = 1'b0;
      end
    end
  endfunction

  function is_reg;
    input [`CRB_ADDR_W-1:0] a;
    input [`CRB_ADDR_W-1:0] r;
    begin
      is_reg = (a == r);
    end
  endfunction

  // ----------------------------------------
  // event decode
  // ----------------------------------------
  // software gate acts as a second enable term
  assign enable_ok = catch_enable_in & ctrl_gate;
  // a full sync symbol or a software sync resets the chain
  assign sync_evt = (sym_done & sym_sync) | soft_sync;
  // half a symbol is enough to tell data from sync
  assign half_data = sym_half & ~sym_half_sync;
  // narrow mode clears bit 8 before the input latch sees it
  assign masked_data = width_mask(sym_data, data_width_select);

  // ----------------------------------------
  // chain output
  // ----------------------------------------
  // registered, so the next receiver sees a clean level one clock
  // after the half symbol that decided it
  assign byte_taken_out = taken;

  // ----------------------------------------
  // capture state machine
  // ----------------------------------------
  always @* begin
    next_state = state;
    next_taken = taken;
    load_in = 1'b0;
    release_byte = 1'b0;
    fall_start = 1'b0;
    fall_abort = 1'b0;
    case (state)
      S_WAIT: begin
        // forced low in case a fall delay was cut short by reset of the chain
        next_taken = 1'b0;
        if (enable_ok) begin
          next_state = S_ARMED;
        end
      end
      S_ARMED: begin
        // a lone sym_done is ignored, so arming mid-symbol waits for the next byte
        if (sync_evt) begin
          next_taken = 1'b0;
        end else if (!enable_ok) begin
          next_state = S_WAIT;
        end else if (half_data) begin
          next_state = S_HALF;
          next_taken = 1'b1;
        end
      end
      S_HALF: begin
        if (sync_evt) begin
          next_taken = 1'b0;
          next_state = enable_ok ? S_ARMED : S_WAIT;
        end else if (!enable_ok) begin
          // enable lost before the byte completed: drop it, only delay the fall
          next_state = S_FALL;
          fall_start = 1'b1;
        end else if (sym_done) begin
          load_in = 1'b1;
          next_state = S_FULL;
        end
      end
      S_FULL: begin
        // later bytes are refused here until sync or a re-enable
        if (sync_evt) begin
          release_byte = in_valid;
          next_taken = 1'b0;
          next_state = enable_ok ? S_ARMED : S_WAIT;
        end else if (!enable_ok) begin
          release_byte = in_valid;
          fall_start = 1'b1;
          next_state = S_FALL;
        end
      end
      S_FALL: begin
        if (sync_evt) begin
          // a sync during the delay lowers byte-taken at once
          fall_abort = 1'b1;
          next_taken = 1'b0;
          next_state = enable_ok ? S_ARMED : S_WAIT;
        end else if (fall_done) begin
          next_taken = 1'b0;
          next_state = S_WAIT;
        end
      end
      default: begin
        // illegal codes recover to waiting
        next_state = S_WAIT;
        next_taken = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      state <= S_WAIT;
      taken <= 1'b0;
    end else begin
      state <= next_state;
      taken <= next_taken;
    end
  end

  // ----------------------------------------
  // input latch
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!nrst) begin
      in_data <= {DW{1'b0}};
      in_cmd <= 1'b0;
      in_viol <= 1'b0;
      in_valid <= 1'b0;
    end else if (load_in) begin
      // held until released, later bytes never overwrite it
      in_data <= masked_data;
      in_cmd <= sym_cmd;
      in_viol <= sym_violation;
      in_valid <= 1'b1;
    end else if (release_byte) begin
      in_valid <= 1'b0;
    end
  end

  // ----------------------------------------
  // released word counter
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!nrst) begin
      words <= {WORD_CW{1'b0}};
    end else if (release_byte) begin
      // wraps silently; software works with differences
      words <= words + {{(WORD_CW-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------
  // byte-taken fall delay
  // ----------------------------------------
  // the delay lets the low level ripple one stage at a time,
  // so downstream receivers release after their upstream neighbour
  crb_fall_delay #(
    .CYC(FALL_CYC),
    .CW(4)
  ) u_fall (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(fall_start),
    .abort(fall_abort),
    .busy(fall_busy),
    .done(fall_done)
  );

  // ----------------------------------------
  // decoder and output latches
  // ----------------------------------------
  crb_out_stage #(
    .DW(DW)
  ) u_out (
    .core_clk(core_clk),
    .nrst(nrst),
    .release_byte(release_byte),
    .in_data(in_data),
    .in_cmd(in_cmd),
    .in_viol(in_viol),
    .data_out(data_out),
    .code_violation_out(code_violation_out),
    .data_out_strobe(data_out_strobe),
    .command_out_strobe(command_out_strobe),
    .dec_pend(dec_pend)
  );

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  // soft sync is a one-cycle pulse after the write
  // the gate resets open so a head receiver works with no set-up
  always @(posedge core_clk) begin
    if (!nrst) begin
      ctrl_gate <= `CRB_CTRL_GATE_RESET;
      soft_sync <= 1'b0;
    end else begin
      soft_sync <= 1'b0;
      if (reg_wr && is_reg(reg_addr, `CRB_REG_CTRL)) begin
        ctrl_gate <= reg_wdata[`CRB_CTRL_GATE];
        soft_sync <= reg_wdata[`CRB_CTRL_SOFT_SYNC];
      end
    end
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  // status bits, low to high: taken, holding, armed, fall busy, decoder pending
  assign status_bits = {dec_pend, fall_busy, state[1], in_valid, taken};

  // read data stands one cycle after the strobe, zero otherwise
  always @* begin
    next_rdata = 32'h00000000;
    if (reg_rd) begin
      if (is_reg(reg_addr, `CRB_REG_CTRL)) begin
        next_rdata = {30'h00000000, ctrl_gate, 1'b0};
      end else if (is_reg(reg_addr, `CRB_REG_STATUS)) begin
        next_rdata = {27'h0000000, status_bits};
      end else if (is_reg(reg_addr, `CRB_REG_OUTDATA)) begin
        next_rdata = {{(30-DW){1'b0}}, in_cmd, in_viol, in_data};
      end else if (is_reg(reg_addr, `CRB_REG_WORDS)) begin
        next_rdata = {{(32-WORD_CW){1'b0}}, words};
      end
    end
  end

  always @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// *** dv/crb_capture_checker.sv ***
// assertions on the ports of the capture block
`timescale 1ns/1ps
`default_nettype none
module crb_capture_checker #(
  parameter DW = 9,
  parameter FALL_CYC = 2
) (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // symbols and chain
  input wire sym_half,
  input wire sym_half_sync,
  input wire sym_done,
  input wire sym_sync,
  input wire catch_enable_in,
  input wire byte_taken_out,
  // outputs
  input wire [DW-1:0] data_out,
  input wire code_violation_out,
  input wire data_out_strobe,
  input wire command_out_strobe
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  localparam int LO = FALL_CYC;
  localparam int HI = FALL_CYC + 1;
  wire strobe_any = data_out_strobe | command_out_strobe;
  wire sync_held = sym_done & sym_sync & byte_taken_out & catch_enable_in;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  property p_taken_rise;
    $rose(byte_taken_out) |-> $past(sym_half && !sym_half_sync);
  endproperty
  a_taken_rise: assert property (p_taken_rise) else $error("taken rose without data");
  property p_sync_half;
    sym_half && sym_half_sync && !byte_taken_out |=> !byte_taken_out;
  endproperty
  a_sync_half: assert property (p_sync_half) else $error("sync raised taken");
  property p_sync_fall;
    sync_held |=> !byte_taken_out;
  endproperty
  a_sync_fall: assert property (p_sync_fall) else $error("taken kept over sync");
  property p_release;
    sync_held |=> !strobe_any ##1 strobe_any;
  endproperty
  a_release: assert property (p_release) else $error("strobe not two after sync");
  property p_strobe_pulse;
    strobe_any |=> !strobe_any;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_data_hold;
    $changed(data_out) |-> strobe_any;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved without strobe");
  property p_viol_hold;
    $changed(code_violation_out) |-> strobe_any;
  endproperty
  a_viol_hold: assert property (p_viol_hold) else $error("violation moved alone");
  property p_idle_enable;
    !catch_enable_in ##1 !catch_enable_in |=> !$rose(byte_taken_out);
  endproperty
  a_idle_enable: assert property (p_idle_enable) else $error("taken while disabled");
  property p_fall_delay;
    byte_taken_out && $fell(catch_enable_in) |-> ##1 byte_taken_out ##[LO:HI] !byte_taken_out;
  endproperty
  a_fall_delay: assert property (p_fall_delay) else $error("taken fall delay wrong");
  c_taken: cover property ($rose(byte_taken_out));
  c_data: cover property (data_out_strobe);
  c_cmd_viol: cover property (command_out_strobe && code_violation_out);
  c_fall: cover property (byte_taken_out && $fell(catch_enable_in));
endmodule
bind crb_capture crb_capture_checker #(.DW(DW), .FALL_CYC(FALL_CYC)) u_chk (
  .core_clk, .nrst, .sym_half, .sym_half_sync, .sym_done, .sym_sync, .catch_enable_in,
  .byte_taken_out, .data_out, .code_violation_out, .data_out_strobe, .command_out_strobe
);
`default_nettype wire

// *** dv/crb_sym_source.sv ***
// transmitter and symbol classifier model feeding the capture block
`timescale 1ns/1ps
`default_nettype none
module crb_sym_source (
  // clock and width
  input wire logic core_clk,
  input wire logic data_width_select,
  // symbols
  output logic sym_half,
  output logic sym_half_sync,
  output logic sym_done,
  output logic sym_sync,
  output logic sym_cmd,
  output logic sym_violation,
  output logic [8:0] sym_data
);
  // ----------------------------------------
  // one symbol every four clocks
  // ----------------------------------------
  initial begin
    {sym_half, sym_half_sync, sym_done, sym_sync, sym_cmd, sym_violation} = 6'h00;
    sym_data = 9'h000;
  end
  task automatic send(input logic s, input logic c, input logic v, input logic [8:0] d);
    @(posedge core_clk);
    sym_half <= 1'b1;
    sym_half_sync <= s;
    @(posedge core_clk);
    sym_half <= 1'b0;
    sym_half_sync <= ~s;
    @(posedge core_clk);
    sym_done <= 1'b1;
    sym_sync <= s;
    sym_cmd <= c;
    sym_violation <= v;
    sym_data <= data_width_select ? d : {1'b0, d[7:0]};
    @(posedge core_clk);
    sym_done <= 1'b0;
    sym_sync <= ~s;
    sym_cmd <= ~c;
    sym_violation <= ~v;
    sym_data <= ~sym_data;
  endtask
endmodule
`default_nettype wire

// *** dv/crb_capture_tb.sv ***
// testbench for the cascade receiver capture block
`timescale 1ns/1ps
`default_nettype none
`include "crb_defines.vh"
module crb_capture_tb;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic data_width_select = 1'b0;
  logic catch_enable_in = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire sym_half, sym_half_sync, sym_done, sym_sync, sym_cmd, sym_violation;
  wire byte_taken_out, code_violation_out, data_out_strobe, command_out_strobe;
  wire [8:0] sym_data, data_out;
  wire [31:0] reg_rdata;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  crb_sym_source src (.core_clk, .data_width_select, .sym_half, .sym_half_sync, .sym_done,
    .sym_sync, .sym_cmd, .sym_violation, .sym_data);
  crb_capture #(.FALL_CYC(1)) dut (.core_clk, .nrst, .sym_half, .sym_half_sync, .sym_done,
    .sym_sync, .sym_cmd, .sym_violation, .sym_data, .data_width_select, .catch_enable_in,
    .byte_taken_out, .data_out, .code_violation_out, .data_out_strobe, .command_out_strobe,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic taken(input logic exp);
    #1 check("byte_taken_out", {31'h0, exp}, {31'h0, byte_taken_out});
  endtask
  task automatic release_wait(input logic [8:0] d, input logic v, input logic c);
    int i;
    for (i = 0; i < 12; i++) begin
      #1;
      if (data_out_strobe === 1'b1 || command_out_strobe === 1'b1) break;
      @(posedge core_clk);
    end
    if (i == 12) begin
      check("strobe", 32'h1, 32'h0);
      results();
    end else begin
      check("data_out", {23'h0, d}, {23'h0, data_out});
      check("violation", {31'h0, v}, {31'h0, code_violation_out});
      check("cmd strobe", {31'h0, c}, {31'h0, command_out_strobe});
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    taken(1'b0);
    rdr(`CRB_REG_CTRL);
    check("ctrl", `CRB_CTRL_RESET, rd);
    wr(4'h2, 32'hFFFFFFFF);
    rdr(4'h2);
    check("unmapped", 32'h0, rd);
    rdr(`CRB_REG_CTRL);
    check("ctrl kept", `CRB_CTRL_RESET, rd);
    $display("test reset end");
    catch_enable_in <= 1'b1;
    src.send(1'b1, 1'b0, 1'b0, 9'h000);
    taken(1'b0);
    src.send(1'b0, 1'b0, 1'b0, 9'h05A);
    taken(1'b1);
    src.send(1'b0, 1'b0, 1'b0, 9'h0C3);
    rdr(`CRB_REG_OUTDATA);
    check("held", 32'h05A, rd);
    rdr(`CRB_REG_STATUS);
    check("status", (32'h1 << `CRB_ST_TAKEN) | (32'h1 << `CRB_ST_HOLD), rd);
    @(posedge core_clk);
    #1 check("rdata idle", 32'h0, reg_rdata);
    src.send(1'b1, 1'b0, 1'b0, 9'h000);
    taken(1'b0);
    release_wait(9'h05A, 1'b0, 1'b0);
    rdr(`CRB_REG_WORDS);
    check("words", 32'h1, rd);
    $display("test word end");
    src.send(1'b0, 1'b1, 1'b1, 9'h0F0);
    taken(1'b1);
    src.send(1'b1, 1'b0, 1'b0, 9'h000);
    release_wait(9'h0F0, 1'b1, 1'b1);
    $display("test violation end");
    catch_enable_in <= 1'b0;
    src.send(1'b0, 1'b0, 1'b0, 9'h011);
    taken(1'b0);
    catch_enable_in <= 1'b1;
    src.send(1'b0, 1'b0, 1'b0, 9'h022);
    taken(1'b1);
    catch_enable_in <= 1'b0;
    release_wait(9'h022, 1'b0, 1'b0);
    repeat (3) @(posedge core_clk);
    taken(1'b0);
    catch_enable_in <= 1'b1;
    src.send(1'b0, 1'b0, 1'b0, 9'h033);
    taken(1'b1);
    src.send(1'b1, 1'b0, 1'b0, 9'h000);
    release_wait(9'h033, 1'b0, 1'b0);
    $display("test rearm end");
    wr(`CRB_REG_CTRL, 32'h0);
    src.send(1'b0, 1'b0, 1'b0, 9'h044);
    taken(1'b0);
    wr(`CRB_REG_CTRL, `CRB_CTRL_RESET);
    $display("test gate end");
    data_width_select <= 1'b1;
    src.send(1'b0, 1'b0, 1'b0, 9'h1A5);
    wr(`CRB_REG_CTRL, 32'h3);
    release_wait(9'h1A5, 1'b0, 1'b0);
    $display("test wide end");
    results();
  end
endmodule
`default_nettype wire
